//--- hw/char_font_addr.sv
`timescale 1ns/1ps
// Contract
// - store 25 rows of 160 codes
// - show 80 columns, rest via scrolling
// - character store at 56k, page zero
// - host top bits, counters give low bits
// - reduced model: 96 characters per line
// - stored code drives font address lines
// - cell 16x12 stored, 12x10 shown
// - screen is 25 rows by 80
// - font 8k x 12 full, half reduced
// - font store reached on page 2
// - superscript adds two to line
// - subscript adds fourteen, modulo sixteen
// - underline and cursor lines never shift
// - font split lower 0-7, upper 8-11
// - lower at 48k, upper at 52k
// - upper takes data 3:0, lower all
// - host top four bits pick part
// - line address picks one of sixteen
// - display first; host gets 260 ns slot
// - shown pixels loaded into 10-bit shifter
module char_font_addr #(
    parameter bit FULL_MODEL = 1'b1
) (
    input wire logic clock_in, // 40 MHz clock
    input wire logic rst_in, // synchronous reset, active high
    input wire logic host_req_in, // host access request, held to ack
    input wire logic host_we_in, // host write when high
    input wire logic [1:0] host_page_in, // host address page
    input wire logic [15:0] host_addr_in, // host address
    input wire logic host_font_set_in, // font set for host access
    input wire logic [7:0] host_data_bits_in, // host write data
    output logic host_ack_out, // one-cycle end of slot
    output logic [7:0] host_data_bits_out, // held host read data
    input wire logic disp_fetch_in, // start one cell fetch
    input wire logic [4:0] disp_row_in, // character row 0..24
    input wire logic [6:0] disp_col_in, // screen column 0..79
    input wire logic [7:0] start_col_in, // scroll start column
    input wire logic [3:0] scan_line_in, // scan line in cell
    input wire logic [1:0] script_in, // none, super or sub
    input wire logic font_set_in, // font set for this cell
    input wire logic underline_in, // cell is underlined
    input wire logic cursor_in, // cursor sits on this cell
    output logic [7:0] char_code_lines_out, // fetched code
    output logic pixel_out, // serial pixel stream
    output logic pixel_active_out, // stream carries a cell
    output logic underline_out, // underline pixel line
    output logic cursor_out // cursor pixel line
);
    localparam int FONT_AW = FULL_MODEL ? text_video_pkg::FONT_AW_FULL
                                        : text_video_pkg::FONT_AW_REDUCED;
    localparam int FONT_DEPTH = 1 << FONT_AW;
    localparam logic [8:0] USABLE_COLS = FULL_MODEL
        ? 9'(text_video_pkg::CHAR_COLS) : 9'(text_video_pkg::REDUCED_COLS);

    typedef enum logic [0:0] {HOST_IDLE, HOST_SLOT} host_state_t;

    host_state_t host_state;
    logic [3:0] slot_cnt;
    logic grant;
    logic hit_char, hit_low, hit_up;
    logic [1:0] host_target;
    logic [8:0] eff_col;
    logic col_blank;
    localparam int CHAR_AW_W = text_video_pkg::CHAR_AW;
    logic [CHAR_AW_W-1:0] disp_char_addr;
    logic [CHAR_AW_W-1:0] char_addr;
    logic char_en, char_we;
    logic [7:0] char_rdata;
    logic [FONT_AW-1:0] font_addr;
    logic [12:0] disp_font_full, host_font_full;
    logic font_en, low_we, up_we;
    logic [7:0] low_rdata;
    logic [3:0] up_rdata;
    logic [3:0] font_line;
    logic [9:0] font_pixel_lines;
    logic s1_valid, s1_blank, s1_set, s1_ul, s1_cur;
    logic [3:0] s1_scan;
    logic [1:0] s1_script;
    logic s2_valid, s2_blank, s2_ul, s2_cur;
    logic hit_char_q;

    // all checks below run on the system clock, quiet during reset
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    // ------------------------------------------------------------
    // host decode and slot arbitration
    // ------------------------------------------------------------

    // the character window is the 4k at top bits E; the 4k above it is unmapped
    assign hit_char = host_page_in == text_video_pkg::CHAR_PAGE
        && host_addr_in[15:12] == text_video_pkg::CHAR_TOP4;
    assign hit_low = host_page_in == text_video_pkg::FONT_PAGE
        && host_addr_in[15:12] == text_video_pkg::FONT_LOW_TOP4;
    assign hit_up = host_page_in == text_video_pkg::FONT_PAGE
        && host_addr_in[15:12] == text_video_pkg::FONT_UP_TOP4;

    // host only touches the stores in a cycle no display stage owns
    assign grant = host_state == HOST_IDLE && host_req_in
        && !disp_fetch_in && !s1_valid;

    // slot timer; ack closes a fixed slot so slot length never varies, only the wait for the grant does
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            host_state <= HOST_IDLE;
            slot_cnt <= 4'h0;
        end else begin
            case (host_state)
                HOST_IDLE: begin
                    if (grant) begin
                        host_state <= HOST_SLOT;
                        slot_cnt <= 4'(text_video_pkg::HOST_SLOT_CYC - 1);
                    end
                end
                HOST_SLOT: begin
                    if (slot_cnt == 4'h0) begin
                        host_state <= HOST_IDLE;
                    end else begin
                        slot_cnt <= slot_cnt - 4'h1;
                    end
                end
                default: host_state <= HOST_IDLE;
            endcase
        end
    end

    assign host_ack_out = host_state == HOST_SLOT && slot_cnt == 4'h0;

    // remember which store the granted access went to
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            host_target <= 2'h0;
        end else if (grant) begin
            host_target <= {hit_up, hit_low | hit_char};
        end
    end

    // holding register, caught one cycle after the grant; the store's
    // own read register may be overwritten by the display afterwards
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            host_data_bits_out <= 8'h00;
        end else if (host_state == HOST_SLOT && slot_cnt == 4'(
                text_video_pkg::HOST_SLOT_CYC - 1)) begin
            if (host_target == 2'h2) begin
                host_data_bits_out <= {4'h0, up_rdata};
            end else if (host_target == 2'h1) begin
                host_data_bits_out <= hit_char_q ? char_rdata
                                                 : low_rdata;
            end else begin
                host_data_bits_out <= text_video_pkg::UNMAPPED_READ;
            end
        end
    end

    // which store a granted access went to, for the late capture
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            hit_char_q <= 1'b0;
        end else if (grant) begin
            hit_char_q <= hit_char;
        end
    end

    // ------------------------------------------------------------
    // character store addressing
    // ------------------------------------------------------------

    // only 80 columns are on screen; the start column slides the window
    assign eff_col = {1'b0, start_col_in} + {2'b00, disp_col_in};
    assign col_blank = eff_col >= USABLE_COLS
        || disp_col_in >= 7'(text_video_pkg::SCREEN_COLS);

    // row * 160 + column, built from shifts to avoid a multiplier
    assign disp_char_addr = {disp_row_in, 7'h00} + {2'b00, disp_row_in, 5'h00}
        + {4'h0, col_blank ? 8'h00 : eff_col[7:0]};

    assign char_en = disp_fetch_in || (grant && hit_char);
    assign char_we = !disp_fetch_in && grant && hit_char && host_we_in;
    assign char_addr = disp_fetch_in ? disp_char_addr
                                     : host_addr_in[CHAR_AW_W-1:0];

    store_ram #(
        .WIDTH(text_video_pkg::CODE_BITS),
        .DEPTH(text_video_pkg::CHAR_DEPTH),
        .AW(CHAR_AW_W)
    ) u_char_ram (
        .clock_in(clock_in),
        .en_in(char_en),
        .we_in(char_we),
        .addr_in(char_addr),
        .wdata_in(host_data_bits_in),
        .rdata_out(char_rdata)
    );

    // ------------------------------------------------------------
    // display pipeline stage one: cell attributes
    // ------------------------------------------------------------

    // underline and cursor use the raw scan line, so script shifts
    // never move them
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            s1_valid <= 1'b0;
            s1_blank <= 1'b0;
            s1_scan <= 4'h0;
            s1_script <= text_video_pkg::SCRIPT_NONE;
            s1_set <= 1'b0;
            s1_ul <= 1'b0;
            s1_cur <= 1'b0;
        end else begin
            s1_valid <= disp_fetch_in;
            if (disp_fetch_in) begin
                s1_blank <= col_blank
                    || scan_line_in >= 4'(text_video_pkg::DISP_LINES);
                s1_scan <= scan_line_in;
                s1_script <= script_in;
                s1_set <= font_set_in;
                s1_ul <= underline_in
                    && scan_line_in == text_video_pkg::UNDERLINE_LINE;
                s1_cur <= cursor_in
                    && scan_line_in >= text_video_pkg::CURSOR_FIRST
                    && scan_line_in <= text_video_pkg::CURSOR_LAST;
            end
        end
    end

    // ------------------------------------------------------------
    // font line and font address
    // ------------------------------------------------------------

    // four-bit sum wraps, which gives the modulo-sixteen subscript
    always_comb begin
        case (s1_script)
            text_video_pkg::SCRIPT_SUPER:
                font_line = s1_scan + text_video_pkg::SUPER_OFFSET;
            text_video_pkg::SCRIPT_SUB:
                font_line = s1_scan + text_video_pkg::SUB_OFFSET;
            default: font_line = s1_scan;
        endcase
    end

    // code lines pick the pattern, line address one of sixteen lines
    assign disp_font_full = {FULL_MODEL ? s1_set : 1'b0,
                             char_rdata, font_line};
    // host: top four bits chose the part, low twelve the word
    assign host_font_full = {FULL_MODEL ? host_font_set_in : 1'b0,
                             host_addr_in[11:0]};
    assign font_addr = s1_valid ? disp_font_full[FONT_AW-1:0]
                                : host_font_full[FONT_AW-1:0];

    assign font_en = s1_valid || (grant && (hit_low || hit_up));
    assign low_we = !s1_valid && grant && hit_low && host_we_in;
    assign up_we = !s1_valid && grant && hit_up && host_we_in;

    store_ram #(
        .WIDTH(text_video_pkg::LOW_PIX_BITS),
        .DEPTH(FONT_DEPTH),
        .AW(FONT_AW)
    ) u_font_low (
        .clock_in(clock_in),
        .en_in(font_en),
        .we_in(low_we),
        .addr_in(font_addr),
        .wdata_in(host_data_bits_in),
        .rdata_out(low_rdata)
    );

    store_ram #(
        .WIDTH(text_video_pkg::UP_PIX_BITS),
        .DEPTH(FONT_DEPTH),
        .AW(FONT_AW)
    ) u_font_up (
        .clock_in(clock_in),
        .en_in(font_en),
        .we_in(up_we),
        .addr_in(font_addr),
        .wdata_in(host_data_bits_in[3:0]),
        .rdata_out(up_rdata)
    );

    // ------------------------------------------------------------
    // display pipeline stage two: code out and serializer load
    // ------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            s2_valid <= 1'b0;
            s2_blank <= 1'b0;
            s2_ul <= 1'b0;
            s2_cur <= 1'b0;
            char_code_lines_out <= 8'h00;
        end else begin
            s2_valid <= s1_valid;
            if (s1_valid) begin
                s2_blank <= s1_blank;
                s2_ul <= s1_ul;
                s2_cur <= s1_cur;
                char_code_lines_out <= char_rdata;
            end
        end
    end

    // marker lines leave with the pixels of the same cell
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            underline_out <= 1'b0;
            cursor_out <= 1'b0;
        end else if (s2_valid) begin
            underline_out <= s2_ul;
            cursor_out <= s2_cur;
        end
    end

    // only pixels 0..9 reach the screen; 10 and 11 stay stored
    assign font_pixel_lines = s2_blank ? 10'h000
                                       : {up_rdata[1:0], low_rdata};

    pixel_shifter #(
        .WIDTH(text_video_pkg::SHOWN_PIX)
    ) u_shifter (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .load_in(s2_valid),
        .par_in(font_pixel_lines),
        .pixel_out(pixel_out),
        .active_out(pixel_active_out)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_granted;
        grant;
    endsequence

    sequence s_quiet_slot;
        !host_ack_out [*8];
    endsequence

    chk_display_first: assert property (
        disp_fetch_in || s1_valid |-> !grant)
        else $error("host granted while display owns the stores");
    chk_slot_length: assert property (
        s_granted |-> ##11 host_ack_out)
        else $error("host slot did not close after 11 cycles");
    chk_slot_quiet: assert property (
        s_granted |=> s_quiet_slot)
        else $error("host ack came early");
    chk_read_hold: assert property (
        host_state == HOST_SLOT && $past(host_state) == HOST_SLOT
        && slot_cnt != 4'(text_video_pkg::HOST_SLOT_CYC - 2)
        |-> $stable(host_data_bits_out))
        else $error("held read data moved inside the slot");
    chk_char_window: assert property (
        grant && host_we_in && host_page_in == 2'h0
        && host_addr_in[15:13] == 3'h7 && !host_addr_in[12] |-> char_we)
        else $error("character write in window not stored");
    chk_upper_part: assert property (
        up_we |-> !low_we && host_addr_in[12] && host_addr_in[15:14] == 2'h3)
        else $error("upper font write misrouted");
    chk_super_line: assert property (
        s1_valid && s1_script == text_video_pkg::SCRIPT_SUPER
        |-> font_line == 4'(s1_scan + 4'h2))
        else $error("superscript line offset wrong");
    chk_sub_line: assert property (
        s1_valid && s1_script == text_video_pkg::SCRIPT_SUB
        |-> font_line == 4'(s1_scan - 4'h2))
        else $error("subscript line offset wrong");
    chk_underline_fixed: assert property (
        disp_fetch_in && underline_in && scan_line_in == 4'hB
        |-> ##3 underline_out)
        else $error("underline moved with script offset");
    chk_code_route: assert property (
        disp_fetch_in ##1 s1_valid |-> font_addr[11:4] == char_rdata)
        else $error("fetched code not on font address");
endmodule

//--- hw/text_video_pkg.sv
package text_video_pkg;

    // ------------------------------------------------------------
    // character store geometry
    // ------------------------------------------------------------
    localparam int CHAR_ROWS = 25;
    localparam int CHAR_COLS = 160;
    localparam int SCREEN_COLS = 80;
    localparam int REDUCED_COLS = 96;
    localparam int CHAR_AW = 12;
    localparam int CHAR_DEPTH = 4096;
    localparam int CODE_BITS = 8;

    // ------------------------------------------------------------
    // font store geometry
    // ------------------------------------------------------------
    localparam int FONT_LINES = 16;
    localparam int DISP_LINES = 12;
    localparam int PIX_BITS = 12;
    localparam int LOW_PIX_BITS = 8;
    localparam int UP_PIX_BITS = 4;
    localparam int SHOWN_PIX = 10;
    localparam int FONT_AW_FULL = 13;
    localparam int FONT_AW_REDUCED = 12;

    // ------------------------------------------------------------
    // line offsets, script modes, fixed marker lines
    // ------------------------------------------------------------
    localparam logic [3:0] SUPER_OFFSET = 4'h2;
    localparam logic [3:0] SUB_OFFSET = 4'hE;
    localparam logic [1:0] SCRIPT_NONE = 2'h0;
    localparam logic [1:0] SCRIPT_SUPER = 2'h1;
    localparam logic [1:0] SCRIPT_SUB = 2'h2;
    localparam logic [3:0] UNDERLINE_LINE = 4'hB;
    localparam logic [3:0] CURSOR_FIRST = 4'hA;
    localparam logic [3:0] CURSOR_LAST = 4'hB;

    // ------------------------------------------------------------
    // host address decode
    // ------------------------------------------------------------
    localparam logic [1:0] CHAR_PAGE = 2'h0;
    localparam logic [1:0] FONT_PAGE = 2'h2;
    localparam logic [3:0] CHAR_TOP4 = 4'hE;
    localparam logic [3:0] FONT_LOW_TOP4 = 4'hC;
    localparam logic [3:0] FONT_UP_TOP4 = 4'hD;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLOCK_MHZ = 40;
    localparam int HOST_SLOT_NS = 260;
    localparam int HOST_SLOT_CYC = (HOST_SLOT_NS * CLOCK_MHZ + 999) / 1000;

endpackage

//--- hw/store_ram.sv
`timescale 1ns/1ps
// single port store, read data held in a register until the next access
module store_ram #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4096,
    parameter int AW = 12
) (
    input wire logic clock_in, // system clock
    input wire logic en_in, // access this cycle
    input wire logic we_in, // write when high
    input wire logic [AW-1:0] addr_in, // word address
    input wire logic [WIDTH-1:0] wdata_in, // write data
    output logic [WIDTH-1:0] rdata_out // registered read data
);
    logic [WIDTH-1:0] mem [DEPTH];

    // write path; no reset so it maps onto block memory
    always_ff @(posedge clock_in) begin
        if (en_in && we_in) begin
            mem[addr_in] <= wdata_in;
        end
    end

    // read path; held between accesses so a host read can be caught late
    always_ff @(posedge clock_in) begin
        if (en_in) begin
            rdata_out <= mem[addr_in];
        end
    end
endmodule

//--- hw/pixel_shifter.sv
`timescale 1ns/1ps
// parallel in, serial out, pixel 0 leaves first
module pixel_shifter #(
    parameter int WIDTH = 10
) (
    input wire logic clock_in, // system clock
    input wire logic rst_in, // synchronous reset
    input wire logic load_in, // load parallel pixels
    input wire logic [WIDTH-1:0] par_in, // pixel line
    output logic pixel_out, // serial pixel
    output logic active_out // high while pixels remain
);
    logic [WIDTH-1:0] shreg;
    logic [4:0] left;

    // a load always wins so a late fetch never slips a cell
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            shreg <= '0;
            left <= 5'h00;
        end else if (load_in) begin
            shreg <= par_in;
            left <= 5'(WIDTH);
        end else if (left != 5'h00) begin
            shreg <= {1'b0, shreg[WIDTH-1:1]};
            left <= left - 5'h01;
        end
    end

    assign pixel_out = shreg[0] & (left != 5'h00);
    assign active_out = (left != 5'h00);

    chk_shift_load: assert property (
        @(posedge clock_in) disable iff (rst_in)
        load_in |=> (pixel_out == $past(par_in[0])) ##0 active_out [*8])
        else $error("shifter did not start on load");
endmodule

//--- sim/disp_timing_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// display timing side: one cell fetch every PERIOD cycles
// ----------------------------------------
module disp_timing_model #(
    parameter int PERIOD = 16
) (
    input wire logic clock_in, // system clock
    input wire logic rst_in, // synchronous reset
    input wire logic run_in, // free-run the beam
    output logic fetch_out, // one-cycle cell fetch
    output logic [6:0] col_out // screen column of the fetch
);
    int cnt;

    // driven off the falling edge so the device samples settled values;
    // a period above ten keeps the cell checks from overlapping
    always @(negedge clock_in) begin
        if (rst_in || !run_in) begin
            fetch_out <= 1'b0;
            cnt <= 0;
            if (rst_in) begin
                col_out <= 7'h00;
            end
        end else begin
            fetch_out <= (cnt == 0);
            cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
            if (fetch_out) begin
                col_out <= (col_out == 7'd79) ? 7'h00 : col_out + 7'h01;
            end
        end
    end
endmodule

//--- sim/char_font_addr_test.sv
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin mismatches++; $display("ERROR %s expected %h seen %h", nm, ex, gt); end end
module char_font_addr_test;
    logic clock_in = 0, rst_in = 1, run = 0, host_req_in = 0, host_we_in = 0;
    logic [1:0] host_page_in = 0, script_in = 0;
    logic [15:0] host_addr_in = 0;
    logic host_font_set_in = 0, font_set_in = 0, underline_in = 0;
    logic cursor_in = 0, host_ack_out, pixel_out, pixel_active_out;
    logic [7:0] host_data_bits_in = 0, host_data_bits_out, char_code_lines_out;
    logic [7:0] start_col_in = 0, code_tab [0:3], char_mem [0:4095];
    logic [4:0] disp_row_in = 0;
    logic [3:0] scan_line_in = 0, line;
    logic [11:0] font_mem [0:8191], pat;
    logic fetch, underline_out, cursor_out, s_ul, s_cur;
    logic [6:0] col;
    int checks = 0, mismatches = 0, seed = 32'h116b33ef, n, adr;

    // ----------------------------------------
    // clock, partner and device
    // ----------------------------------------
    initial begin
        forever #12.5 clock_in = ~clock_in;
    end
    disp_timing_model #(.PERIOD(16)) u_tim (.clock_in(clock_in),
        .rst_in(rst_in), .run_in(run), .fetch_out(fetch), .col_out(col));
    char_font_addr #(.FULL_MODEL(1'b1)) u_dut (.clock_in(clock_in),
        .rst_in(rst_in), .host_req_in(host_req_in), .host_we_in(host_we_in),
        .host_page_in(host_page_in), .host_addr_in(host_addr_in),
        .host_font_set_in(host_font_set_in),
        .host_data_bits_in(host_data_bits_in), .host_ack_out(host_ack_out),
        .host_data_bits_out(host_data_bits_out), .disp_fetch_in(fetch),
        .disp_row_in(disp_row_in), .disp_col_in(col),
        .start_col_in(start_col_in), .scan_line_in(scan_line_in),
        .script_in(script_in), .font_set_in(font_set_in),
        .underline_in(underline_in), .cursor_in(cursor_in),
        .char_code_lines_out(char_code_lines_out), .pixel_out(pixel_out),
        .pixel_active_out(pixel_active_out), .underline_out(underline_out),
        .cursor_out(cursor_out));

    // ----------------------------------------
    // host bus cycle: request held until the acknowledge edge
    // ----------------------------------------
    task automatic host_op(input logic we, input logic [1:0] pg,
                           input logic [15:0] a, input logic [7:0] d);
        int w;
        @(negedge clock_in);
        host_req_in = 1'b1;
        host_we_in = we;
        host_page_in = pg;
        host_addr_in = a;
        host_data_bits_in = d;
        w = 0;
        while (host_ack_out !== 1'b1 && w < 400) begin
            @(negedge clock_in);
            w++;
        end
        if (w >= 400) begin
            mismatches++;
            $display("ERROR host_ack expected 1 seen timeout");
        end
        @(negedge clock_in);
        host_req_in = 1'b0;
    endtask

    task give_verdict;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // a hang costs at most this many cycles, well above the expected run
    initial begin
        repeat (60000) @(posedge clock_in);
        mismatches++;
        give_verdict();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (10) @(negedge clock_in);
        rst_in = 1'b0;
        `CHK("ack_reset", 1'b0, host_ack_out)
        `CHK("active_reset", 1'b0, pixel_active_out)
        `CHK("code_reset", 8'h00, char_code_lines_out)
        // fonts: lower then upper byte, unused lines blanked by the loader
        for (int s = 0; s < 2; s++) begin
            host_font_set_in = s[0];
            for (int i = 0; i < 4; i++) begin
                code_tab[i] = (s == 0) ? $random(seed) : code_tab[i];
                for (int l = 0; l < 16; l++) begin
                    pat = (l >= 12) ? 12'h000 : $random(seed);
                    adr = {code_tab[i], l[3:0]};
                    font_mem[{s[0], adr[11:0]}] = pat;
                    host_op(1'b1, 2'h2, 16'hc000 | adr[15:0], pat[7:0]);
                    n = $random(seed);
                    host_op(1'b1, 2'h2, 16'hd000 | adr[15:0],
                            {n[3:0], pat[11:8]});
                end
            end
        end
        // read back a shown line, not one of the blanked ones
        adr = {code_tab[3], 4'h5};
        pat = font_mem[{1'b1, adr[11:0]}];
        host_op(1'b0, 2'h2, 16'hd000 | adr[15:0], 8'h00);
        `CHK("font_upper", {4'h0, pat[11:8]}, host_data_bits_out)
        host_op(1'b0, 2'h2, 16'hc000 | adr[15:0], 8'h00);
        `CHK("font_lower", pat[7:0], host_data_bits_out)
        $display("test fonts done");
        // one row of codes written while the display keeps fetching
        disp_row_in = 5'($unsigned($random(seed)) % 25);
        run = 1'b1;
        for (int c = 0; c < 160; c++) begin
            adr = disp_row_in * 160 + c;
            char_mem[adr] = code_tab[$unsigned($random(seed)) % 4];
            host_op(1'b1, 2'h0, 16'he000 + adr[15:0], char_mem[adr]);
        end
        host_op(1'b0, 2'h0, 16'he000 + adr[15:0], 8'h00);
        `CHK("char_read", char_mem[adr], host_data_bits_out)
        host_op(1'b0, 2'h0, 16'hf000, 8'h00);
        `CHK("unmapped_read", 8'h00, host_data_bits_out)
        $display("test host done");
        // display cells: random scroll, scan line, script and markers
        for (int k = 0; k < 80; k++) begin
            n = 0;
            @(posedge clock_in);
            while (fetch !== 1'b1 && n < 40) begin
                @(posedge clock_in);
                n++;
            end
            `CHK("fetch", 1'b1, fetch)
            adr = disp_row_in * 160 + start_col_in + col;
            line = scan_line_in + ((script_in == text_video_pkg::SCRIPT_SUPER) ?
                text_video_pkg::SUPER_OFFSET :
                (script_in == text_video_pkg::SCRIPT_SUB) ?
                text_video_pkg::SUB_OFFSET : 4'h0);
            pat = (scan_line_in >= 12) ? 12'h000 :
                font_mem[{font_set_in, char_mem[adr], line}];
            s_ul = underline_in && scan_line_in == 4'hb;
            s_cur = cursor_in && scan_line_in >= 4'ha && scan_line_in <= 4'hb;
            @(negedge clock_in);
            n = $random(seed);
            start_col_in = (k == 5) ? 8'd80 : 8'($unsigned(n) % 81);
            scan_line_in = n[11:8];
            script_in = 2'($unsigned(n[15:12]) % 3);
            font_set_in = n[16];
            underline_in = n[17];
            cursor_in = n[18];
            // corner: marker line with both markers on
            if (k == 7) begin
                scan_line_in = 4'hb;
                underline_in = 1'b1;
                cursor_in = 1'b1;
            end
            @(negedge clock_in);
            `CHK("code", char_mem[adr], char_code_lines_out)
            for (int p = 0; p < 10; p++) begin
                @(negedge clock_in);
                if (p == 0) begin
                    `CHK("underline", s_ul, underline_out)
                    `CHK("cursor", s_cur, cursor_out)
                end
                `CHK("active", 1'b1, pixel_active_out)
                `CHK("pixel", pat[p], pixel_out)
            end
        end
        $display("test display done");
        give_verdict();
    end
endmodule
